// [rtl/chg_cfg_regs.sv]
// charger current, voltage and timer configuration registers with decode.
// assumes the serial-port slave gives single-cycle strobes on core_clk.
//
// Functional notes
// - pre-charge code decodes by table; 0000/0001 give 128, 0101 gives 768 mA.
// - pre-charge code resets to 0001, 128 mA; range 128 to 2048 mA.
// - termination code weights 128/256/512 mA plus 128 mA offset.
// - termination code resets to 001; whole register resets to 0x11.
// - voltage code weights 16 to 512 mV over 3.504 V; top 4.400 V.
// - voltage code resets to 101100, 4.208 V; register resets to 0xb2.
// - bit 1 selects fast-charge entry 2.8 V or 3.0 V; resets to 1.
// - bit 0 selects recharge drop 100 or 300 mV; resets to 0.
// - bit 7 of timer register enables termination; resets to 1.
// - battery-switch reset enable resets only on power-on or soft reset.
// - watchdog code: off, 40 s, 80 s, 160 s; resets to 01.
// - bit 3 enables safety timer; bits 2:1 pick 5/8/12/20 hrs.
// - time limit resets to 10, 12 hrs; register resets to 0xdc.
// - soft register reset restores defaults; no request keeps settings.
// - reduced-current control halves applied pre-charge current.
module chg_cfg_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // register access from the serial-port slave
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // reset sources besides nrst
  input wire logic soft_rst,
  input wire logic sys_rst,
  // control from elsewhere in the map
  input wire logic force_reduced_current,
  // decoded settings
  output chg_cfg_pkg::charge_settings_s settings
);
  // ==========================================
  // elaboration checks
  if (DATA_W != 8) begin : g_bad_data
    $error("chg_cfg_regs: DATA_W must be 8");
  end
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
    $error("chg_cfg_regs: ADDR_W must be 3 to 8");
  end

  // ==========================================
  // storage
  logic [7:0] pre_term_ff;
  logic [7:0] volt_ff;
  logic [7:0] timer_ff;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  chg_cfg_pkg::charge_settings_s settings_ff;
  chg_cfg_pkg::charge_settings_s nxt_settings;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    // zero-extend; ADDR_W never exceeds 8
    return 8'(a) == ofs;
  endfunction : hit

  logic wr_pre_term;
  logic wr_volt;
  logic wr_timer;
  logic any_rst;

  assign wr_pre_term = wr_en && hit(addr, chg_cfg_pkg::ADDR_PRE_TERM);
  assign wr_volt = wr_en && hit(addr, chg_cfg_pkg::ADDR_VOLT);
  assign wr_timer = wr_en && hit(addr, chg_cfg_pkg::ADDR_TIMER);
  // a reset request in the same cycle as a write wins
  assign any_rst = soft_rst || sys_rst;

  // ==========================================
  // pre-charge and termination register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_term_ff <= chg_cfg_pkg::RST_PRE_TERM;
    end else if (clk_en) begin
      if (any_rst) begin
        pre_term_ff <= chg_cfg_pkg::RST_PRE_TERM;
      end else if (wr_pre_term) begin
        pre_term_ff <= wr_data;
      end
    end
  end

  // ==========================================
  // charge voltage register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      volt_ff <= chg_cfg_pkg::RST_VOLT;
    end else if (clk_en) begin
      if (any_rst) begin
        volt_ff <= chg_cfg_pkg::RST_VOLT;
      end else if (wr_volt) begin
        volt_ff <= wr_data;
      end
    end
  end

  // ==========================================
  // termination and timer register
  // battery-switch reset enable survives every reset but power-on and soft
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= chg_cfg_pkg::RST_TIMER;
    end else if (clk_en) begin
      if (soft_rst) begin
        timer_ff <= chg_cfg_pkg::RST_TIMER;
      end else if (sys_rst) begin
        timer_ff <= chg_cfg_pkg::RST_TIMER;
        timer_ff[chg_cfg_pkg::BSR_BIT] <= timer_ff[chg_cfg_pkg::BSR_BIT];
      end else if (wr_timer) begin
        timer_ff <= wr_data;
      end
    end
  end

  // ==========================================
  // read port
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= chg_cfg_pkg::RD_UNMAPPED;
      rd_valid_ff <= 1'b0;
    end else if (clk_en) begin
      rd_valid_ff <= rd_en;
      if (rd_en) begin
        if (hit(addr, chg_cfg_pkg::ADDR_PRE_TERM)) begin
          rd_data_ff <= pre_term_ff;
        end else if (hit(addr, chg_cfg_pkg::ADDR_VOLT)) begin
          rd_data_ff <= volt_ff;
        end else if (hit(addr, chg_cfg_pkg::ADDR_TIMER)) begin
          rd_data_ff <= timer_ff;
        end else begin
          rd_data_ff <= chg_cfg_pkg::RD_UNMAPPED;
        end
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;

  // ==========================================
  // decode and settings register
  chg_setting_decode u_decode (
    .pre_term(pre_term_ff),
    .volt(volt_ff),
    .timer(timer_ff),
    .force_reduced_current(force_reduced_current),
    .settings(nxt_settings)
  );

  // one cycle behind the registers; settings never glitch mid-cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      settings_ff <= '0;
    end else if (clk_en) begin
      settings_ff <= nxt_settings;
    end
  end

  assign settings = settings_ff;

  // ==========================================
  // checks
  // checks wait one enabled edge past reset release; that edge still resets
  logic armed_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_ff <= 1'b0;
    end else if (clk_en) begin
      armed_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst || !armed_ff);

  chk_pre_lut: assert property (
    clk_en |=> 13'(settings_ff.precharge_ma) ==
      ((($past(pre_term_ff[7:4]) < 4'h2) ? 13'h080 :
        ($past(pre_term_ff[7:4]) < 4'h5) ? (13'($past(pre_term_ff[7:4])) << 7) :
        (13'($past(pre_term_ff[7:4]) + 5'h01) << 7)) >> $past(force_reduced_current)))
    else $error("pre-charge current wrong");

  chk_pre_reduce: assert property (
    clk_en && force_reduced_current && pre_term_ff[7:4] == 4'h5 |=>
      settings_ff.precharge_ma == 12'h180)
    else $error("reduced pre-charge not half");

  chk_term_decode: assert property (
    clk_en |=> settings_ff.term_ma ==
      11'h080 + 11'($past(pre_term_ff[2:0])) * 11'h080)
    else $error("termination current wrong");

  chk_volt_decode: assert property (
    clk_en && volt_ff[7:2] == 6'h2c |=> settings_ff.charge_mv == 13'h1070)
    else $error("charge voltage wrong");

  chk_volt_top: assert property (
    clk_en |=> settings_ff.charge_mv <= 13'h1130)
    else $error("charge voltage above top");

  chk_soft_defaults: assert property (
    clk_en && soft_rst |=> pre_term_ff == 8'h11 && volt_ff == 8'hb2 &&
      timer_ff == 8'hdc ##1
      settings_ff.limit_hrs == 5'h0c || !$past(clk_en))
    else $error("soft reset defaults wrong");

  chk_bsr_keep: assert property (
    clk_en && sys_rst && !soft_rst |=>
      timer_ff[6] == $past(timer_ff[6]) && timer_ff[5:4] == 2'h1)
    else $error("battery-switch enable lost on system reset");

  chk_thresholds: assert property (
    clk_en |=> settings_ff.entry_mv ==
      ($past(volt_ff[1]) ? 12'hbb8 : 12'haf0) &&
      settings_ff.recharge_mv == ($past(volt_ff[0]) ? 9'h12c : 9'h064))
    else $error("threshold select wrong");

  chk_timer_fields: assert property (
    clk_en |=> settings_ff.term_en == $past(timer_ff[7]) &&
      settings_ff.timer_en == $past(timer_ff[3]) &&
      settings_ff.wdog_s == (($past(timer_ff[5:4]) == 2'h0) ? 8'h00 :
        (8'h14 << $past(timer_ff[5:4]))) &&
      settings_ff.limit_hrs == (($past(timer_ff[2:1]) == 2'h0) ? 5'h05 :
        ($past(timer_ff[2:1]) == 2'h1) ? 5'h08 :
        ($past(timer_ff[2:1]) == 2'h2) ? 5'h0c : 5'h14))
    else $error("timer control decode wrong");

  chk_reserved_store: assert property (
    clk_en && wr_pre_term && !any_rst |=> pre_term_ff == $past(wr_data))
    else $error("write not stored");

  chk_freeze: assert property (
    !clk_en |=> $stable(pre_term_ff) && $stable(volt_ff) &&
      $stable(timer_ff) && $stable(settings_ff))
    else $error("state moved with enable low");

  chk_volt_store: assert property (
    clk_en && wr_volt && !any_rst |=> volt_ff == $past(wr_data))
    else $error("voltage write not stored");

  chk_timer_store: assert property (
    clk_en && wr_timer && !any_rst |=> timer_ff == $past(wr_data))
    else $error("timer write not stored");

  chk_sys_defaults: assert property (
    clk_en && sys_rst && !soft_rst |=> pre_term_ff == 8'h11 && volt_ff == 8'hb2 &&
      timer_ff[7] && timer_ff[3:0] == 4'hc)
    else $error("system reset defaults wrong");

  chk_rd_timer: assert property (
    clk_en && rd_en && hit(addr, chg_cfg_pkg::ADDR_TIMER) |=>
      rd_valid && rd_data == $past(timer_ff))
    else $error("timer register read wrong");

  chk_rd_volt: assert property (
    clk_en && rd_en && hit(addr, chg_cfg_pkg::ADDR_VOLT) |=>
      rd_valid && rd_data == $past(volt_ff))
    else $error("voltage register read wrong");

  chk_rd_unmapped: assert property (
    clk_en && rd_en && !hit(addr, chg_cfg_pkg::ADDR_PRE_TERM) && !hit(addr, chg_cfg_pkg::ADDR_VOLT)
      && !hit(addr, chg_cfg_pkg::ADDR_TIMER) |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped read not zero");

  chk_rd_pulse: assert property (
    clk_en && !rd_en |=> !rd_valid)
    else $error("read valid without a read");

  chk_pre_range: assert property (
    clk_en && !force_reduced_current |=> settings_ff.precharge_ma >= 12'h080 &&
      settings_ff.precharge_ma <= 12'h800)
    else $error("pre-charge current out of range");

  chk_term_range: assert property (
    clk_en |=> settings_ff.term_ma >= 11'h080 && settings_ff.term_ma <= 11'h400)
    else $error("termination current out of range");

  chk_volt_floor: assert property (
    clk_en |=> settings_ff.charge_mv >= 13'hdb0)
    else $error("charge voltage below offset");

  cov_write_read: cover property (
    clk_en && wr_volt ##1 clk_en && rd_en && hit(addr, chg_cfg_pkg::ADDR_VOLT));
  cov_soft_rst: cover property (clk_en && soft_rst && timer_ff[6] == 1'b0);
  cov_sys_rst: cover property (clk_en && sys_rst && timer_ff[6] == 1'b0);
  cov_reduced: cover property (clk_en && force_reduced_current);
  cov_unmapped_rd: cover property (clk_en && rd_en && hit(addr, 8'h06));
endmodule : chg_cfg_regs

// [include/chg_cfg_pkg.sv]
// charger configuration registers: addresses, reset values, field layout,
// decoded setting bundle and the decode functions called by the rtl decode.
// assumes the serial-port slave presents one byte access per strobe.
package chg_cfg_pkg;
  // ==========================================
  // register addresses and reset values
  localparam logic [7:0] ADDR_PRE_TERM = 8'h03;
  localparam logic [7:0] ADDR_VOLT = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h05;
  localparam logic [7:0] RST_PRE_TERM = 8'h11;
  localparam logic [7:0] RST_VOLT = 8'hb2;
  localparam logic [7:0] RST_TIMER = 8'hdc;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ==========================================
  // field positions
  localparam int PRE_HI = 7;
  localparam int PRE_LO = 4;
  localparam int TERM_HI = 2;
  localparam int TERM_LO = 0;
  localparam int CHARGE_VOLTAGE_CODE_HI = 7;
  localparam int CHARGE_VOLTAGE_CODE_LO = 2;
  localparam int LOWV_BIT = 1;
  localparam int RECHG_BIT = 0;
  localparam int TERM_EN_BIT = 7;
  localparam int BSR_BIT = 6;
  localparam int WDOG_HI = 5;
  localparam int WDOG_LO = 4;
  localparam int TMR_EN_BIT = 3;
  localparam int TMR_HI = 2;
  localparam int TMR_LO = 1;
  // ==========================================
  // setting units (ma, mv, s, hrs)
  localparam logic [10:0] TERM_STEP_MA = 11'h080;
  localparam logic [12:0] CHARGE_VOLTAGE_CODE_OFS_MV = 13'hdb0;
  localparam logic [12:0] CHARGE_VOLTAGE_CODE_STEP_MV = 13'h010;
  localparam logic [12:0] CHARGE_VOLTAGE_CODE_MAX_MV = 13'h1130;
  localparam logic [11:0] LOWV_0_MV = 12'haf0;
  localparam logic [11:0] LOWV_1_MV = 12'hbb8;
  localparam logic [8:0] RECHG_0_MV = 9'h064;
  localparam logic [8:0] RECHG_1_MV = 9'h12c;

  typedef struct packed {
    logic [11:0] precharge_ma;
    logic [10:0] term_ma;
    logic [12:0] charge_mv;
    logic [11:0] entry_mv;
    logic [8:0] recharge_mv;
    logic term_en;
    logic bsr_en;
    logic [7:0] wdog_s;
    logic timer_en;
    logic [4:0] limit_hrs;
  } charge_settings_s;

  // ==========================================
  // decode functions
  // not linear: 0101 jumps to 768, both 0000 and 0001 give 128
  function automatic logic [11:0] precharge_lut(input logic [3:0] code);
    logic [11:0] ma;
    case (code)
      4'h0, 4'h1: ma = 12'h080;
      4'h2: ma = 12'h100;
      4'h3: ma = 12'h180;
      4'h4: ma = 12'h200;
      default: ma = {4'h0, code, 4'h0} + {4'h0, code, 4'h0} +
                    {4'h0, code, 4'h0} + {4'h0, code, 4'h0} +
                    {4'h0, code, 4'h0} + {4'h0, code, 4'h0} +
                    {4'h0, code, 4'h0} + {4'h0, code, 4'h0} + 12'h080;
    endcase
    return ma;
  endfunction : precharge_lut

  function automatic logic [10:0] term_ma(input logic [2:0] code);
    return TERM_STEP_MA + 11'(code) * TERM_STEP_MA;
  endfunction : term_ma

  function automatic logic [12:0] charge_mv(input logic [5:0] code);
    logic [12:0] mv;
    mv = CHARGE_VOLTAGE_CODE_OFS_MV + 13'(code) * CHARGE_VOLTAGE_CODE_STEP_MV;
    return (mv > CHARGE_VOLTAGE_CODE_MAX_MV) ? CHARGE_VOLTAGE_CODE_MAX_MV : mv;
  endfunction : charge_mv

  function automatic logic [7:0] wdog_s(input logic [1:0] code);
    case (code)
      2'h1: return 8'h28;
      2'h2: return 8'h50;
      2'h3: return 8'ha0;
      default: return 8'h00;
    endcase
  endfunction : wdog_s

  function automatic logic [4:0] limit_hrs(input logic [1:0] code);
    case (code)
      2'h0: return 5'h05;
      2'h1: return 5'h08;
      2'h2: return 5'h0c;
      default: return 5'h14;
    endcase
  endfunction : limit_hrs
endpackage : chg_cfg_pkg

// [rtl/chg_setting_decode.sv]
// field decode of the three configuration bytes into charger settings.
// assumes the caller registers the result; purely combinational here.
module chg_setting_decode (
  // register contents
  input wire logic [7:0] pre_term,
  input wire logic [7:0] volt,
  input wire logic [7:0] timer,
  // halve pre-charge current
  input wire logic force_reduced_current,
  // decoded settings
  output chg_cfg_pkg::charge_settings_s settings
);
  // ==========================================
  // decode
  logic [11:0] pre_full;

  always_comb begin
    pre_full = chg_cfg_pkg::precharge_lut(
      pre_term[chg_cfg_pkg::PRE_HI:chg_cfg_pkg::PRE_LO]);
    settings = '0;
    // halving by shift keeps the table exact for every code
    settings.precharge_ma = force_reduced_current ? (pre_full >> 1) : pre_full;
    settings.term_ma = chg_cfg_pkg::term_ma(
      pre_term[chg_cfg_pkg::TERM_HI:chg_cfg_pkg::TERM_LO]);
    settings.charge_mv = chg_cfg_pkg::charge_mv(
      volt[chg_cfg_pkg::CHARGE_VOLTAGE_CODE_HI:chg_cfg_pkg::CHARGE_VOLTAGE_CODE_LO]);
    settings.entry_mv = volt[chg_cfg_pkg::LOWV_BIT] ?
      chg_cfg_pkg::LOWV_1_MV : chg_cfg_pkg::LOWV_0_MV;
    settings.recharge_mv = volt[chg_cfg_pkg::RECHG_BIT] ?
      chg_cfg_pkg::RECHG_1_MV : chg_cfg_pkg::RECHG_0_MV;
    settings.term_en = timer[chg_cfg_pkg::TERM_EN_BIT];
    settings.bsr_en = timer[chg_cfg_pkg::BSR_BIT];
    settings.wdog_s = chg_cfg_pkg::wdog_s(
      timer[chg_cfg_pkg::WDOG_HI:chg_cfg_pkg::WDOG_LO]);
    settings.timer_en = timer[chg_cfg_pkg::TMR_EN_BIT];
    settings.limit_hrs = chg_cfg_pkg::limit_hrs(
      timer[chg_cfg_pkg::TMR_HI:chg_cfg_pkg::TMR_LO]);
  end
endmodule : chg_setting_decode

// [tb/chg_host_model.sv]
// host model: byte writes, byte reads and soft reset on the register port.
// assumes one core_clk domain; every strobe starts just after a rising edge.
module chg_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // register-reset request
  output logic soft_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    soft_rst = 1'b0;
  end
  // =========================================
  // bus cycles
  // released lines show the inverse, never a stale match
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk);
      if (rd_valid === 1'b1) begin
        d = rd_data;
        ok = 1'b1;
      end
    end
  endtask : read_reg
  // one-cycle pulse on soft_rst, the register-reset request
  task automatic soft_reset();
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
  endtask : soft_reset
endmodule : chg_host_model

// [tb/chg_cfg_regs_tb.sv]
// self-checking bench for the charger configuration registers.
// assumes chg_cfg_pkg is compiled first; host model in its own file.
module chg_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic sys_rst = 1'b0;
  logic force_reduced_current = 1'b0;
  logic wr_en, rd_en, soft_rst, rd_valid;
  logic [7:0] addr, wr_data, rd_data;
  chg_cfg_pkg::charge_settings_s settings;
  int num_errors = 0;
  int tests_run = 0;
  always #4 core_clk = ~core_clk;
  chg_cfg_regs i_chg_cfg_regs (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .soft_rst(soft_rst), .sys_rst(sys_rst),
    .force_reduced_current(force_reduced_current), .settings(settings));
  chg_host_model i_chg_host_model (.core_clk(core_clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .soft_rst(soft_rst));
  // =========================================
  // compare and bus helpers
  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check_byte
  task automatic check_val(input string n, input logic [12:0] e, input logic [12:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask : check_val
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    i_chg_host_model.read_reg(a, d, ok);
    if (!ok) begin
      num_errors++;
      $display("unexpected read timeout expected %h seen none", e);
      final_report();
    end else begin
      check_byte("register", e, d);
    end
  endtask : rd_chk
  // settings follow one enabled edge after the register
  task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
    i_chg_host_model.write_reg(a, d);
    repeat (3) @(posedge core_clk);
  endtask : wr_wait
  // =========================================
  // scenarios
  task automatic t_defaults();
    rd_chk(8'h03, 8'h11);
    rd_chk(8'h04, 8'hb2);
    rd_chk(8'h05, 8'hdc);
    check_val("precharge", 13'd128, 13'(settings.precharge_ma));
    check_val("term", 13'd256, 13'(settings.term_ma));
    check_val("charge", 13'd4208, settings.charge_mv);
    check_val("entry", 13'd3000, 13'(settings.entry_mv));
    check_val("recharge", 13'd100, 13'(settings.recharge_mv));
    check_val("term_en", 13'd1, 13'(settings.term_en));
    check_val("bsr_en", 13'd1, 13'(settings.bsr_en));
    check_val("wdog", 13'd40, 13'(settings.wdog_s));
    check_val("timer_en", 13'd1, 13'(settings.timer_en));
    check_val("limit", 13'd12, 13'(settings.limit_hrs));
  endtask : t_defaults
  task automatic t_current();
    int p;
    for (int i = 0; i < 16; i++) begin
      wr_wait(8'h03, {i[3:0], 1'b0, i[2:0]});
      p = (i < 2) ? 128 : (i < 5) ? i * 128 : (i + 1) * 128;
      check_val("precharge", 13'(p), 13'(settings.precharge_ma));
      check_val("term", 13'((i % 8 + 1) * 128), 13'(settings.term_ma));
    end
    @(posedge core_clk);
    force_reduced_current <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_val("reduced", 13'd1024, 13'(settings.precharge_ma));
    wr_wait(8'h03, 8'h51);
    check_val("reduced", 13'd384, 13'(settings.precharge_ma));
    force_reduced_current <= 1'b0;
  endtask : t_current
  task automatic t_voltage();
    int mv;
    for (int i = 0; i < 64; i++) begin
      wr_wait(8'h04, {i[5:0], i[1:0]});
      mv = (3504 + 16 * i > 4400) ? 4400 : 3504 + 16 * i;
      check_val("charge", 13'(mv), settings.charge_mv);
      check_val("entry", i[1] ? 13'd3000 : 13'd2800, 13'(settings.entry_mv));
      check_val("recharge", i[0] ? 13'd300 : 13'd100, 13'(settings.recharge_mv));
    end
  endtask : t_voltage
  task automatic t_timer();
    int wd[4] = '{0, 40, 80, 160};
    int hr[4] = '{5, 8, 12, 20};
    for (int i = 0; i < 16; i++) begin
      wr_wait(8'h05, {i[0], 1'b1, i[1:0], ~i[0], i[3:2], 1'b0});
      check_val("term_en", 13'(i[0]), 13'(settings.term_en));
      check_val("wdog", 13'(wd[i % 4]), 13'(settings.wdog_s));
      check_val("timer_en", 13'(!i[0]), 13'(settings.timer_en));
      check_val("limit", 13'(hr[i / 4]), 13'(settings.limit_hrs));
    end
  endtask : t_timer
  task automatic t_resets();
    wr_wait(8'h05, 8'h00);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(8'h05, 8'h9c);
    check_val("bsr_en", 13'd0, 13'(settings.bsr_en));
    i_chg_host_model.soft_reset();
    rd_chk(8'h05, 8'hdc);
    rd_chk(8'h04, 8'hb2);
    check_val("bsr_en", 13'd1, 13'(settings.bsr_en));
    // power-on reset mid-run restores the battery-switch enable too
    wr_wait(8'h05, 8'h00);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(8'h05, 8'hdc);
    check_val("bsr_en", 13'd1, 13'(settings.bsr_en));
    check_val("precharge", 13'd128, 13'(settings.precharge_ma));
  endtask : t_resets
  // reserved bit, unmapped place and a gated strobe
  task automatic t_refused();
    wr_wait(8'h03, 8'h19);
    rd_chk(8'h03, 8'h19);
    check_val("precharge", 13'd128, 13'(settings.precharge_ma));
    check_val("term", 13'd256, 13'(settings.term_ma));
    wr_wait(8'h06, 8'hff);
    rd_chk(8'h06, 8'h00);
    clk_en <= 1'b0;
    wr_wait(8'h03, 8'hff);
    clk_en <= 1'b1;
    rd_chk(8'h03, 8'h19);
  endtask : t_refused
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_defaults();
    t_current();
    t_voltage();
    t_timer();
    t_resets();
    t_refused();
    final_report();
  end
endmodule : chg_cfg_regs_tb
